// [verilog/sec_engine.sv]
module sec_engine import sec_pkg::*; #(
   parameter int unsigned P_WORD_CYC = WORD_CYC,
   parameter int unsigned P_ERASE_ALL_CMD_CYC = ERASE_ALL_CMD_CYC,
   parameter int unsigned P_WRITE_ALL_CMD_CYC = WRITE_ALL_CMD_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select,
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic width_strap_pin,
   output logic serial_out,
   output logic serial_out_oe_n
);
   sec_pins_s pins_raw;
   sec_pins_s pins_s;
   logic cs_d_r;
   logic sclk_d_r;
   logic sclk_rise;
   logic cs_rise;
   logic cs_fall;
   logic go_r;
   logic start;
   logic wide_r;
   sec_state_e state_r;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic [SH_W-1:0] sh_r;
   logic [SH_W-1:0] sh_nxt;
   logic [4:0] hdr_len;
   logic [4:0] dat_len;
   logic shift_en;
   logic hdr_done;
   logic all_done;
   logic [1:0] opc;
   logic [1:0] sub;
   logic [8:0] hdr_addr;
   logic [15:0] in_word;
   sec_op_e hdr_op;
   sec_op_e cmd_op_r;
   logic [8:0] cmd_addr_r;
   logic en_r;
   sec_prog_s pend_r;
   logic pend_v_r;
   logic prog_go;
   logic busy_r;
   logic [TMR_W-1:0] tmr_r;
   logic [CSL_W-1:0] csl_r;
   logic stat_r;
   logic wr_all;
   logic wr_one;
   logic [IDX_W-1:0] wr_idx;
   logic [15:0] wr_data;
   logic [15:0] wr_mask;
   logic [15:0] mem_q [NWORDS];
   logic [8:0] rd_addr_r;
   logic fetch_on_r;
   logic [IDX_W-1:0] rd_idx;
   logic [15:0] rd_word;
   logic fifo_in_ready;
   sec_word_s fifo_in;
   logic fifo_out_valid;
   logic fifo_pop;
   sec_word_s fifo_out;
   logic [15:0] aligned;
   logic [15:0] out_sh_r;
   logic [4:0] left_r;

   // pin bundle into the clock domain
   assign pins_raw = '{cs: chip_select, sclk: serial_clk,
                       si: serial_in, ws: width_strap_pin};

   sec_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pins_in(pins_raw),
      .pins_sync(pins_s)
   );

   // edge detection on synchronised select and serial clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cs_d_r <= 1'b0;
         sclk_d_r <= 1'b0;
         go_r <= 1'b0;
      end else begin
         cs_d_r <= pins_s.cs;
         sclk_d_r <= pins_s.sclk;
         go_r <= cs_fall; // a last bit seen with the fall still counts
      end
   end

   assign sclk_rise = pins_s.sclk && !sclk_d_r; // R4 R23
   assign cs_rise = pins_s.cs && !cs_d_r;
   assign cs_fall = cs_d_r && !pins_s.cs;

   // start only from idle and never while a cycle runs
   assign start = (state_r == SEC_IDLE) && pins_s.cs && sclk_rise
                  && pins_s.si && !busy_r; // R7 R8

   // strap taken at start so a change mid-frame cannot split it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wide_r <= 1'b0;
      end else if (start) begin
         wide_r <= pins_s.ws; // R3
      end
   end

   // framing decode from the incoming bit stream
   always_comb begin
      sh_nxt = {sh_r[SH_W-2:0], pins_s.si};
      cnt_nxt = cnt_r + 5'h01;
      hdr_len = wide_r ? HDR_X16 : HDR_X8; // R1 R24
      dat_len = wide_r ? DAT_X16 : DAT_X8;
      shift_en = (state_r == SEC_SHIFT) && sclk_rise;
      hdr_done = shift_en && (cnt_nxt == hdr_len);
      all_done = shift_en && (cnt_nxt == hdr_len + dat_len); // R9
      opc = wide_r ? sh_nxt[9:8] : sh_nxt[10:9];
      sub = wide_r ? sh_nxt[7:6] : sh_nxt[8:7]; // R1
      hdr_addr = wide_r ? {1'b0, sh_nxt[7:0]} : sh_nxt[8:0];
      in_word = wide_r ? sh_nxt[15:0] : {8'h00, sh_nxt[7:0]};
      hdr_op = SEC_OP_NONE;
      case (opc)
         OPC_WRITE: hdr_op = SEC_OP_WRITE;
         OPC_ERASE: hdr_op = SEC_OP_ERASE;
         OPC_EXT: begin
            if (sub == SUB_ERASE_ALL_CMD) begin
               hdr_op = SEC_OP_ERASE_ALL_CMD;
            end else if (sub == SUB_WRITE_ALL_CMD) begin
               hdr_op = SEC_OP_WRITE_ALL_CMD;
            end
         end
         default: hdr_op = SEC_OP_NONE;
      endcase
   end

   // control state; select low forces idle
   always_ff @(posedge clk) begin
      if (sys_rst || !pins_s.cs) begin
         state_r <= SEC_IDLE; // R22
      end else begin
         case (state_r)
            SEC_IDLE: begin
               if (start) begin
                  state_r <= SEC_SHIFT;
               end
            end
            SEC_SHIFT: begin
               if (hdr_done) begin
                  if (opc == OPC_READ) begin
                     state_r <= SEC_READ;
                  end else if (hdr_op != SEC_OP_WRITE
                               && hdr_op != SEC_OP_WRITE_ALL_CMD) begin
                     state_r <= SEC_DONE;
                  end
               end else if (all_done) begin
                  state_r <= SEC_DONE; // R10
               end
            end
            SEC_READ: state_r <= SEC_READ;
            SEC_DONE: state_r <= SEC_DONE; // R10
            default: state_r <= SEC_IDLE;
         endcase
      end
   end

   // shifter holds its bits while the serial clock pauses
   always_ff @(posedge clk) begin
      if (sys_rst || start) begin
         cnt_r <= 5'h00;
         sh_r <= '0;
      end else if (shift_en) begin
         cnt_r <= cnt_nxt; // R23
         sh_r <= sh_nxt; // R4
      end
   end

   // header capture for commands that carry data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd_op_r <= SEC_OP_NONE;
         cmd_addr_r <= 9'h000;
      end else if (hdr_done) begin
         cmd_op_r <= hdr_op;
         cmd_addr_r <= hdr_addr;
      end
   end

   // programming enable latch, cleared at power-up or by the disable command
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_r <= 1'b0; // R11
      end else if (hdr_done && opc == OPC_EXT) begin
         if (sub == SUB_EN) begin
            en_r <= 1'b1;
         end else if (sub == SUB_DIS) begin
            en_r <= 1'b0; // R11
         end
      end
   end

   // complete program commands wait here for the select fall
   always_ff @(posedge clk) begin
      if (sys_rst || go_r) begin
         pend_v_r <= 1'b0;
      end else if (hdr_done && (hdr_op == SEC_OP_ERASE
                                || hdr_op == SEC_OP_ERASE_ALL_CMD)) begin
         pend_r <= '{op: hdr_op, addr: hdr_addr, data: ERASED};
         pend_v_r <= 1'b1; // R15 R18
      end else if (all_done) begin
         pend_r <= '{op: cmd_op_r, addr: cmd_addr_r, data: in_word};
         pend_v_r <= 1'b1; // R9
      end
   end

   // an aborted frame never set the pending flag
   assign prog_go = go_r && pend_v_r && en_r; // R11 R15 R17 R19

   // array write controls; x8 write-all repeats the byte
   always_comb begin
      wr_all = prog_go && (pend_r.op == SEC_OP_ERASE_ALL_CMD
                           || pend_r.op == SEC_OP_WRITE_ALL_CMD); // R18 R19
      wr_one = prog_go && !wr_all;
      wr_idx = wide_r ? pend_r.addr[7:0] : pend_r.addr[8:1];
      wr_data = wide_r ? pend_r.data
                       : {pend_r.data[7:0], pend_r.data[7:0]};
      if (wide_r || wr_all) begin
         wr_mask = ERASED;
      end else begin
         wr_mask = pend_r.addr[0] ? MASK_HI : MASK_LO;
      end
   end

   // storage in flip-flops, one entry per word
   for (genvar gi = 0; gi < NWORDS; gi++) begin : g_mem
      logic [15:0] word_r;
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            word_r <= ERASED;
         end else if (wr_all
                      || (wr_one && wr_idx == IDX_W'(gi))) begin
            word_r <= (word_r & ~wr_mask) | (wr_data & wr_mask);
         end
      end
      assign mem_q[gi] = word_r;
   end

   // self-timed cycle; array updates at once, busy covers the time
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_r <= 1'b0;
         tmr_r <= '0;
      end else if (prog_go) begin
         busy_r <= 1'b1; // R21
         case (pend_r.op)
            SEC_OP_ERASE_ALL_CMD: tmr_r <= TMR_W'(P_ERASE_ALL_CMD_CYC - 1); // R20
            SEC_OP_WRITE_ALL_CMD: tmr_r <= TMR_W'(P_WRITE_ALL_CMD_CYC - 1);
            default: tmr_r <= TMR_W'(P_WORD_CYC - 1);
         endcase
      end else if (busy_r) begin
         if (tmr_r == '0) begin
            busy_r <= 1'b0; // R25
         end else begin
            tmr_r <= tmr_r - 1'b1;
         end
      end
   end

   // select low time, saturating
   always_ff @(posedge clk) begin
      if (sys_rst || pins_s.cs) begin
         csl_r <= '0;
      end else if (csl_r != CSL_W'(CSL_CYC)) begin
         csl_r <= csl_r + 1'b1;
      end
   end

   // status mode: raised select while busy after a long enough low
   always_ff @(posedge clk) begin
      if (sys_rst || !pins_s.cs || start) begin
         stat_r <= 1'b0;
      end else if (cs_rise && busy_r
                   && csl_r == CSL_W'(CSL_CYC)) begin
         stat_r <= 1'b1; // R16
      end
   end

   // read prefetch address, byte or word stepping
   always_ff @(posedge clk) begin
      if (sys_rst || !pins_s.cs) begin
         fetch_on_r <= 1'b0;
         rd_addr_r <= 9'h000;
      end else if (hdr_done && opc == OPC_READ) begin
         fetch_on_r <= 1'b1; // R12
         rd_addr_r <= hdr_addr;
      end else if (fetch_on_r && fifo_in_ready) begin
         if (wide_r) begin
            rd_addr_r <= {1'b0, rd_addr_r[7:0] + 8'h01}; // R14
         end else begin
            rd_addr_r <= rd_addr_r + 9'h001; // R14
         end
      end
   end

   assign rd_idx = wide_r ? rd_addr_r[7:0] : rd_addr_r[8:1];
   always_comb begin
      rd_word = mem_q[rd_idx];
      if (!wide_r) begin
         rd_word = rd_addr_r[0] ? {8'h00, rd_word[15:8]}
                                : {8'h00, rd_word[7:0]};
      end
   end
   assign fifo_in = '{data: rd_word, wide: wide_r};

   // a slow host only stalls the prefetch, no word is lost
   sec_buf u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .flush(!pins_s.cs),
      .in_valid(fetch_on_r),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   assign fifo_pop = (state_r == SEC_READ) && sclk_rise
                     && left_r == 5'h00 && fifo_out_valid;
   assign aligned = fifo_out.wide ? fifo_out.data
                                  : {fifo_out.data[7:0], 8'h00};

   // read serialiser, next word follows with no gap
   always_ff @(posedge clk) begin
      if (sys_rst || !pins_s.cs || hdr_done) begin
         out_sh_r <= 16'h0000;
         left_r <= 5'h00;
      end else if (fifo_pop) begin
         out_sh_r <= {aligned[14:0], 1'b0}; // R13
         left_r <= (fifo_out.wide ? DAT_X16 : DAT_X8) - 5'h01;
      end else if ((state_r == SEC_READ) && sclk_rise
                   && left_r != 5'h00) begin
         out_sh_r <= {out_sh_r[14:0], 1'b0};
         left_r <= left_r - 5'h01;
      end
   end

   // data out pin; enable is low while driving
   always_ff @(posedge clk) begin
      if (sys_rst || !pins_s.cs || start) begin
         serial_out <= 1'b1;
         serial_out_oe_n <= 1'b1; // R5
      end else if (stat_r) begin
         serial_out <= !busy_r; // R6
         serial_out_oe_n <= 1'b0;
      end else if (hdr_done && opc == OPC_READ) begin
         serial_out <= 1'b0; // R13
         serial_out_oe_n <= 1'b0;
      end else if (fifo_pop) begin
         serial_out <= aligned[15]; // R13
      end else if ((state_r == SEC_READ) && sclk_rise
                   && left_r != 5'h00) begin
         serial_out <= out_sh_r[15];
      end
   end
endmodule

// [verilog/sec_pkg.sv]
// Notes on behaviour
// R1 - x8: start, two-bit opcode, nine address bits
// R2 - host gives 20 or 12 edges in x8
// R3 - strap high selects x16, low x8
// R4 - serial input sampled on serial clock rise
// R5 - output floats except read or status
// R6 - status low while busy, high when ready
// R7 - start is first edge with select, input high
// R8 - nothing happens before start; select leaves standby
// R9 - execute only after all bits; aborts harmless
// R10 - after last bit, ignore until next start
// R11 - programming disabled at power-up until enabled
// R12 - reads run regardless of enable latch
// R13 - read sends dummy zero then word, MSB first
// R14 - select held high continues with next address
// R15 - erase sets word to ones at select fall
// R16 - status shown if select low 250 ns first
// R17 - host drops select before edge after data
// R18 - erase-all fills ones, self-timed, no clocks
// R19 - write-all fills array, needs enable latch
// R20 - busy held 4, 8 or 16 ms
// R21 - started cycle completes despite select low
// R22 - select low holds control logic in reset
// R23 - serial clock may pause, state is kept
// R24 - x16: eight address bits, 27 or 11 edges
// R25 - cycle timed by counter, busy until expiry
package sec_pkg;
   // clock rate and documented times
   localparam int CLK_KHZ = 40000;
   localparam int CLK_MHZ = 40;
   localparam int T_CSL_NS = 250;
   localparam int T_WORD_MS = 4;
   localparam int T_ERASE_ALL_CMD_MS = 8;
   localparam int T_WRITE_ALL_CMD_MS = 16;
   // least time rounds up to whole cycles
   localparam int CSL_CYC = (T_CSL_NS * CLK_MHZ + 999) / 1000;
   localparam int WORD_CYC = T_WORD_MS * CLK_KHZ;
   localparam int ERASE_ALL_CMD_CYC = T_ERASE_ALL_CMD_MS * CLK_KHZ;
   localparam int WRITE_ALL_CMD_CYC = T_WRITE_ALL_CMD_MS * CLK_KHZ;
   localparam int TMR_W = 20;
   localparam int CSL_W = 4;
   // array and framing
   localparam int NWORDS = 256;
   localparam int IDX_W = 8;
   localparam int SH_W = 27;
   localparam int BUF_DEPTH = 2;
   localparam logic [4:0] HDR_X8 = 5'h0B;
   localparam logic [4:0] HDR_X16 = 5'h0A;
   localparam logic [4:0] DAT_X8 = 5'h08;
   localparam logic [4:0] DAT_X16 = 5'h10;
   localparam logic [15:0] ERASED = 16'hFFFF;
   localparam logic [15:0] MASK_LO = 16'h00FF;
   localparam logic [15:0] MASK_HI = 16'hFF00;
   // opcodes and extended sub-codes
   localparam logic [1:0] OPC_EXT = 2'h0;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_ERASE = 2'h3;
   localparam logic [1:0] SUB_DIS = 2'h0;
   localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;
   localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
   localparam logic [1:0] SUB_EN = 2'h3;

   typedef enum logic [3:0] {
      SEC_IDLE = 4'h1,
      SEC_SHIFT = 4'h2,
      SEC_READ = 4'h4,
      SEC_DONE = 4'h8
   } sec_state_e;

   typedef enum logic [2:0] {
      SEC_OP_NONE = 3'h0,
      SEC_OP_ERASE = 3'h1,
      SEC_OP_WRITE = 3'h2,
      SEC_OP_ERASE_ALL_CMD = 3'h3,
      SEC_OP_WRITE_ALL_CMD = 3'h4
   } sec_op_e;

   typedef struct packed {
      logic cs;
      logic sclk;
      logic si;
      logic ws;
   } sec_pins_s;

   typedef struct packed {
      logic [15:0] data;
      logic wide;
   } sec_word_s;

   typedef struct packed {
      sec_op_e op;
      logic [8:0] addr;
      logic [15:0] data;
   } sec_prog_s;
endpackage

// [verilog/sec_sync.sv]
module sec_sync import sec_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input sec_pins_s pins_in,
   output sec_pins_s pins_sync
);
   sec_pins_s meta_r;

   // two-flop synchroniser, first stage read only by the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         pins_sync <= '0;
      end else begin
         meta_r <= pins_in;
         pins_sync <= meta_r;
      end
   end
endmodule

// [verilog/sec_buf.sv]
module sec_buf import sec_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input sec_word_s in_data,
   output logic out_valid,
   input wire logic out_ready,
   output sec_word_s out_data
);
   sec_word_s ent_r [BUF_DEPTH];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;

   // full stalls the fetcher, empty stalls the serialiser
   assign in_ready = (cnt_r != 2'(BUF_DEPTH));
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = ent_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointers and fill level; flush drops stale prefetch
   always_ff @(posedge clk) begin
      if (sys_rst || flush) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         wp_r <= wp_r ^ push;
         rp_r <= rp_r ^ pop;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // entry storage
   always_ff @(posedge clk) begin
      if (push) begin
         ent_r[wp_r] <= in_data;
      end
   end
endmodule

// [bench/sec_engine_props.sv]
module sec_engine_props #(
   parameter int unsigned P_WORD_CYC = 40,
   parameter int unsigned P_ERASE_ALL_CMD_CYC = 80,
   parameter int unsigned P_WRITE_ALL_CMD_CYC = 160
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select,
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic width_strap_pin,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [3:0] low_cnt_r;
   logic [3:0] last_low_r;
   logic stat_r;
   logic [19:0] stat_cnt_r;

   // length of the latest deselect gap, saturating so long idles stay legal
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         low_cnt_r <= 4'h0;
         last_low_r <= 4'h0;
      end else if (!chip_select) begin
         low_cnt_r <= (low_cnt_r == 4'hF) ? low_cnt_r : low_cnt_r + 4'h1;
      end else begin
         last_low_r <= (low_cnt_r == 4'h0) ? last_low_r : low_cnt_r;
         low_cnt_r <= 4'h0;
      end
   end

   // status mode: output switched on with the serial clock parked low
   always_ff @(posedge clk) begin
      if (sys_rst || serial_out_oe_n) begin
         stat_r <= 1'b0;
      end else if ($fell(serial_out_oe_n) && !serial_clk) begin
         stat_r <= 1'b1;
      end
   end

   // cycles of busy shown in one poll
   always_ff @(posedge clk) begin
      if (sys_rst || !stat_r || serial_out) begin
         stat_cnt_r <= 20'h00000;
      end else begin
         stat_cnt_r <= stat_cnt_r + 20'h00001;
      end
   end

   sequence s_cs_gone;
      (!chip_select) [*6];
   endsequence
   sequence s_clk_still;
      (!serial_clk) [*3];
   endsequence

   property p_float_on_deselect;
      s_cs_gone |-> serial_out_oe_n;
   endproperty
   property p_idle_high;
      serial_out_oe_n |-> serial_out;
   endproperty
   property p_rst_float;
      disable iff (1'b0) $fell(sys_rst) |-> serial_out_oe_n && serial_out;
   endproperty
   property p_drive_needs_select;
      $fell(serial_out_oe_n) |-> $past(chip_select, 2);
   endproperty
   property p_drive_starts_low;
      $fell(serial_out_oe_n) |-> !serial_out;
   endproperty
   property p_read_bit_on_rise;
      !serial_out_oe_n && !$past(serial_out_oe_n) && !stat_r &&
         $changed(serial_out) |-> $past(serial_clk) || $past(serial_clk, 2);
   endproperty
   property p_status_gap;
      $fell(serial_out_oe_n) && !serial_clk && !$past(serial_clk)
         |-> last_low_r >= 4'hA;
   endproperty
   property p_busy_bounded;
      {12'h000, stat_cnt_r} <= P_WRITE_ALL_CMD_CYC;
   endproperty
   property p_ready_holds;
      stat_r && serial_out && !serial_out_oe_n |=>
         serial_out || serial_out_oe_n;
   endproperty
   property p_hold_in_pause;
      s_clk_still ##0 (!serial_out_oe_n && !$past(serial_out_oe_n) && !stat_r)
         |-> $stable(serial_out);
   endproperty

   a_float_on_deselect: assert property (p_float_on_deselect)
      else $error("output still driven after deselect");
   a_idle_high: assert property (p_idle_high)
      else $error("undriven output value not high");
   a_rst_float: assert property (p_rst_float)
      else $error("output driven right after reset");
   a_drive_needs_select: assert property (p_drive_needs_select)
      else $error("output enabled without select");
   a_drive_starts_low: assert property (p_drive_starts_low)
      else $error("first driven bit not low");
   a_read_bit_on_rise: assert property (p_read_bit_on_rise)
      else $error("read bit changed without serial clock rise");
   a_status_gap: assert property (p_status_gap)
      else $error("status shown after too short a deselect");
   a_busy_bounded: assert property (p_busy_bounded)
      else $error("busy shown longer than the longest cycle");
   a_ready_holds: assert property (p_ready_holds)
      else $error("ready status dropped back to busy");
   a_hold_in_pause: assert property (p_hold_in_pause)
      else $error("read output moved while serial clock parked");
endmodule

bind sec_engine sec_engine_props #(
   .P_WORD_CYC(P_WORD_CYC),
   .P_ERASE_ALL_CMD_CYC(P_ERASE_ALL_CMD_CYC),
   .P_WRITE_ALL_CMD_CYC(P_WRITE_ALL_CMD_CYC)
) u_props (
   .clk(clk),
   .sys_rst(sys_rst),
   .chip_select(chip_select),
   .serial_clk(serial_clk),
   .serial_in(serial_in),
   .width_strap_pin(width_strap_pin),
   .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n)
);

// [bench/sec_host_model.sv]
module sec_host_model (
   input wire logic clk,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   output logic chip_select,
   output logic serial_clk,
   output logic serial_in
);
   timeunit 1ns;
   timeprecision 100ps;

   // deselected, serial clock parked low between frames
   initial begin
      chip_select = 1'b0;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end

   // data line toggled on release so nobody leans on its last value
   task automatic deselect;
      chip_select <= 1'b0;
      serial_in <= ~serial_in;
      repeat (12) @(posedge clk);
   endtask

   // one frame, MSB first; output sampled just before each rise and once
   // after the last rise, so rx ends with the final bit shifted out
   task automatic send(input int n, input logic [63:0] v, input int pz,
         output logic [63:0] rx);
      rx = 64'h0;
      chip_select <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         serial_in <= v[i];
         serial_clk <= 1'b0;
         repeat ((i == pz) ? 40 : 4) @(posedge clk);
         rx = {rx[62:0], serial_out};
         serial_clk <= 1'b1;
         repeat (4) @(posedge clk);
      end
      serial_clk <= 1'b0;
      repeat (4) @(posedge clk);
      rx = {rx[62:0], serial_out};
      deselect();
   endtask

   // raise select after the gap and wait for ready, bounded
   task automatic poll(output int t, output logic shown);
      t = 0;
      chip_select <= 1'b1;
      repeat (6) @(posedge clk);
      shown = !serial_out_oe_n && !serial_out;
      while (serial_out !== 1'b1 && t < 1000) begin
         @(posedge clk);
         t++;
      end
      deselect();
   endtask
endmodule

// [bench/tb.sv]
module tb import sec_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int PW = 40;
   localparam int PE = 80;
   localparam int PL = 160;

   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic strap = 1'b1;
   logic cs, sclk, si, so, oe_n;
   logic en = 1'b0;
   logic [15:0] mem [NWORDS];
   logic [63:0] rx;
   logic [8:0] a;
   logic [15:0] d;
   int errors = 0;
   int n_compared = 0;
   integer seed = 32'hf43f;

`define CHK(what, exp, got) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("unexpected %s: expected %h seen %h", what, exp, got); \
   end \
end

   always #12.5 clk = ~clk;

   sec_host_model u_host (.clk(clk), .serial_out(so), .serial_out_oe_n(oe_n),
      .chip_select(cs), .serial_clk(sclk), .serial_in(si));

   sec_engine #(.P_WORD_CYC(PW), .P_ERASE_ALL_CMD_CYC(PE), .P_WRITE_ALL_CMD_CYC(PL)) dut (
      .clk(clk), .sys_rst(sys_rst), .chip_select(cs), .serial_clk(sclk),
      .serial_in(si), .width_strap_pin(strap), .serial_out(so),
      .serial_out_oe_n(oe_n));

   function automatic logic [1:0] sub_of(input logic [8:0] x);
      return strap ? x[7:6] : x[8:7];
   endfunction
   function automatic logic [8:0] sub_addr(input logic [1:0] s);
      return strap ? {1'b0, s, 6'h00} : {s, 7'h00};
   endfunction
   function automatic logic [8:0] amask(input logic [8:0] x);
      return strap ? {1'b0, x[7:0]} : x;
   endfunction
   // x8 byte lane: odd address is the upper half of the word
   function automatic logic [15:0] exp_rd(input logic [8:0] x);
      logic [15:0] w;
      w = mem[strap ? x[7:0] : x[8:1]];
      return strap ? w : (x[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
   endfunction
   // updates the array model, returns the busy span or 0 when no cycle starts (refused, enable, disable)
   function automatic int upd(input logic [1:0] op, input logic [8:0] x,
         input logic [15:0] v);
      logic [1:0] s;
      s = sub_of(x);
      v = strap ? v : {v[7:0], v[7:0]};
      if (op == OPC_EXT && (s == SUB_EN || s == SUB_DIS)) begin
         en = (s == SUB_EN);
         return 0;
      end
      if (!en || op == OPC_READ) begin
         return 0;
      end
      if (op == OPC_EXT) begin
         foreach (mem[i]) mem[i] = (s == SUB_ERASE_ALL_CMD) ? ERASED : v;
         return (s == SUB_ERASE_ALL_CMD) ? PE : PL;
      end
      v = (op == OPC_ERASE) ? ERASED : v;
      if (strap) mem[x[7:0]] = v;
      else if (x[0]) mem[x[8:1]][15:8] = v[7:0];
      else mem[x[8:1]][7:0] = v[7:0];
      return PW;
   endfunction

   // random leading idle edges, tz trailing edges, cut bits dropped at end
   task automatic cmd(input logic [1:0] op, input logic [8:0] x,
         input logic [15:0] v, input int words, input int tz, input int cut);
      int hn;
      int dn;
      logic [63:0] f;
      hn = strap ? 11 : 12;
      dn = (strap ? 16 : 8) * words;
      if (op == OPC_ERASE || (op == OPC_EXT && sub_of(x) != SUB_WRITE_ALL_CMD)) begin
         dn = 0;
      end
      f = {62'h0, op} | 64'h4;
      f = (f << (hn - 3)) | {55'h0, amask(x)};
      f = (f << dn) | {48'h0, (op == OPC_READ || dn == 0) ? 16'h0000 : v};
      f = (f << tz) >> cut;
      u_host.send(hn + dn + tz - cut + ($random(seed) & 3), f,
         $random(seed) & 63, rx);
   endtask

   task automatic do_op(input logic [1:0] op, input logic [8:0] x,
         input logic [15:0] v, input int tz, input int cut);
      int p;
      int t;
      logic shown;
      cmd(op, x, strap ? v : {8'h00, v[7:0]}, 1, tz, cut);
      p = (cut == 0) ? upd(op, x, v) : 0;
      u_host.poll(t, shown);
      `CHK("status shown", p > 0, shown)
      if (p > 0) begin
         `CHK("busy span", 1'b1, t >= p - 20 && t <= p - 8)
      end
   endtask

   task automatic chk_read(input logic [8:0] x, input int words);
      int w;
      logic [15:0] g;
      w = strap ? 16 : 8;
      cmd(OPC_READ, x, 16'h0000, words, 0, 0);
      `CHK("dummy bit", 1'b0, rx[w * words])
      for (int k = 0; k < words; k++) begin
         g = rx[(words - 1 - k) * w +: 16] & (strap ? 16'hFFFF : 16'h00FF);
         `CHK("read word", exp_rd(amask(x + 9'(k))), g)
      end
   endtask

   task automatic set_strap(input logic s);
      strap <= s;
      @(posedge clk);
   endtask

   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("unexpected watchdog: expected finish seen hang");
      wrap_up();
   end

   initial begin
      foreach (mem[i]) mem[i] = ERASED;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("float after reset", 1'b1, oe_n)
      chk_read(9'($random(seed)), 1);
      do_op(OPC_WRITE, 9'h023, 16'hA5C3, 0, 0);
      chk_read(9'h023, 1);
      $display("test power-up protection done");
      do_op(OPC_EXT, sub_addr(SUB_EN), 16'h0000, 3, 0);
      for (int i = 0; i < 8; i++) begin
         set_strap(1'($random(seed)));
         a = 9'($random(seed));
         d = 16'($random(seed));
         do_op((i % 3 == 0) ? OPC_ERASE : OPC_WRITE, a, d, 0, 0);
         chk_read(a, 1 + (i & 1));
      end
      for (int s = 0; s < 2; s++) begin
         set_strap(1'(s));
         chk_read(9'h1FF, 2);
      end
      $display("test random programming done");
      do_op(OPC_WRITE, 9'h005, 16'h1234, 0, 3);
      chk_read(9'h005, 1);
      do_op(OPC_EXT, sub_addr(SUB_ERASE_ALL_CMD), 16'h0000, 0, 0);
      chk_read(9'($random(seed)), 2);
      set_strap(1'b0);
      do_op(OPC_EXT, sub_addr(SUB_WRITE_ALL_CMD), 16'h003C, 0, 0);
      chk_read(9'($random(seed)), 2);
      $display("test whole-array cycles done");
      do_op(OPC_EXT, sub_addr(SUB_DIS), 16'h0000, 0, 0);
      do_op(OPC_WRITE, 9'h0AA, 16'h0055, 0, 0);
      chk_read(9'h0AA, 1);
      $display("test disable done");
      wrap_up();
   end
endmodule
